// *** dv/ppc_pin_model.sv ***
// Circuit at the pins: resolves each wire from the pad controls.
// Assumes an outside source beats a pull but loses to strong drive.
`timescale 1ns/1ps
module ppc_pin_model
   import ppc_pkg::*;
(
   input wire logic i_clock,
   input wire logic [PPC_PINS-1:0] i_data,
   input wire logic [PPC_PINS-1:0] i_oe_n,
   input wire logic [PPC_PINS-1:0] i_pull_up,
   input wire logic [PPC_PINS-1:0] i_pull_down,
   input wire logic [PPC_PINS-1:0] i_ext_en,
   input wire logic [PPC_PINS-1:0] i_ext_val,
   output logic [PPC_PINS-1:0] o_level
);
   // A floating wire flips every cycle so it never reads as a quiet level.
   logic [PPC_PINS-1:0] float_r = '0;
   always_ff @(posedge i_clock)
   begin
      float_r <= ~o_level;
   end
   always_comb
   begin
      for (int i = 0; i < PPC_PINS; i++)
      begin
         if (!i_oe_n[i])
            o_level[i] = i_data[i];
         else if (i_ext_en[i])
            o_level[i] = i_ext_val[i];
         else if (i_pull_up[i] || i_pull_down[i])
            o_level[i] = i_pull_up[i];
         else
            o_level[i] = float_r[i];
      end
   end
endmodule

// *** dv/ppc_port_props.sv ***
// Concurrent checks on the port pin controller's top-level ports.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
module ppc_port_props
   import ppc_pkg::*;
#(
   parameter int PINS = PPC_PINS,
   parameter int OE_LINES = PPC_OE_LINES
)
(
   input wire logic I_CLOCK,
   input wire logic I_RESET,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [PPC_ADDR_W-1:0] I_PADDR,
   input wire logic [31:0] O_PRDATA,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   input wire logic [PINS-1:0] O_PIN_OE_N,
   input wire logic [PINS-1:0] O_PULL_UP,
   input wire logic [PINS-1:0] O_PULL_DOWN,
   input wire logic [PINS-1:0] O_IN_BUF_EN,
   input wire logic [PINS-1:0] O_SLOW_EDGE,
   input wire logic O_PORT_IRQ
);
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_RESET);
   logic stat_rd;
   assign stat_rd = I_PSEL && I_PENABLE && !I_PWRITE && I_PADDR == PPC_OFS_STAT;
   ////////////////////////////////////////
   a_ready_next: assert property (I_PSEL && !I_PENABLE |=> O_PREADY)
      else $error("ready missing after setup");
   a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready longer than one cycle");
   a_err_quiet: assert property (O_PSLVERR |-> O_PREADY && !(|O_PRDATA))
      else $error("error without ready or with data");
   // Reset itself is the trigger here, so nothing may disable it.
   a_reset_hiz: assert property
      (@(posedge I_CLOCK) disable iff (1'b0) I_RESET |=> &O_PIN_OE_N
      && !(|{O_PULL_UP, O_PULL_DOWN, O_IN_BUF_EN}) && !O_PORT_IRQ)
      else $error("pads not idle after reset");
   a_strong_nopull: assert property
      (!(|(~O_PIN_OE_N & (O_PULL_UP | O_PULL_DOWN))))
      else $error("strong drive with a pull on");
   a_pull_excl: assert property (!(|(O_PULL_UP & O_PULL_DOWN)))
      else $error("pull up and down together");
   a_slew_resist: assert property
      (!(|(O_SLOW_EDGE & (O_PULL_UP | O_PULL_DOWN))))
      else $error("slow edge in a resistive state");
   a_irq_sticky: assert property ($fell(O_PORT_IRQ) |->
      $past(stat_rd) || $past(stat_rd, 2))
      else $error("request dropped without a status read");
   cover property ($rose(O_PORT_IRQ));
   cover property (O_PSLVERR);
   cover property (I_PSEL && I_PENABLE && I_PWRITE && O_PREADY);
endmodule
bind ppc_port ppc_port_props #(.PINS(PINS), .OE_LINES(OE_LINES)) u_props
(
   .I_CLOCK, .I_RESET, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
   .O_PRDATA, .O_PREADY, .O_PSLVERR, .O_PIN_OE_N, .O_PULL_UP,
   .O_PULL_DOWN, .O_IN_BUF_EN, .O_SLOW_EDGE, .O_PORT_IRQ
);

// *** dv/testbench.sv ***
// Self-checking bench for the port pin controller over APB.
// Assumes the bound checker and the pin model at the pads.
`timescale 1ns/1ps
module testbench;
   import ppc_pkg::*;
   logic clk, rst, psel, pen, pwrite, pslverr, pready, lvttl, irq, err;
   logic [PPC_ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] oe_bus;
   logic [7:0] pin_lvl, sys_out, bypass, pin_d, oe_n, pu, pd, ibuf, slow;
   logic [7:0] pin_in, reg_lvl, thr, ext_val;
   logic [2:0] e;
   int num_errors = 0;
   int n_tests = 0;
   ppc_port uut
   (
      .I_CLOCK(clk),
      .I_RESET(rst),
      .I_PSEL(psel),
      .I_PENABLE(pen),
      .I_PWRITE(pwrite),
      .I_PADDR(paddr),
      .I_PWDATA(pwdata),
      .O_PRDATA(prdata),
      .O_PREADY(pready),
      .O_PSLVERR(pslverr),
      .I_PIN(pin_lvl),
      .I_OE_BUS(oe_bus),
      .I_SYS_OUT(sys_out),
      .I_BYPASS(bypass),
      .O_PIN(pin_d),
      .O_PIN_OE_N(oe_n),
      .O_PULL_UP(pu),
      .O_PULL_DOWN(pd),
      .O_IN_BUF_EN(ibuf),
      .O_SLOW_EDGE(slow),
      .O_PIN_IN(pin_in),
      .O_LVTTL(lvttl),
      .O_REG_LEVEL(reg_lvl),
      .O_PAIR_THRESH(thr),
      .O_PORT_IRQ(irq)
   );
   ppc_pin_model u_pins
   (
      .i_clock(clk),
      .i_data(pin_d),
      .i_oe_n(oe_n),
      .i_pull_up(pu),
      .i_pull_down(pd),
      .i_ext_en(8'hFF),
      .i_ext_val(ext_val),
      .o_level(pin_lvl)
   );
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [63:0] s, e);
      n_tests++;
      if (s !== e)
      begin
         num_errors++;
         $display("FAIL %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input int d);
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   task automatic rdc(input logic [11:0] a, input int x);
      bus(1'h0, a, 0);
      chk("read", rd, x);
   endtask
   task automatic gap(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic int rep(input logic b);
      return b ? 32'hFF : 32'h0;
   endfunction
   function automatic logic [2:0] exp_pad(input int m, input logic d);
      case (m)
         2: return d ? 3'h6 : 3'h0;
         3: return d ? 3'h0 : 3'h5;
         4: return d ? 3'h4 : 3'h0;
         5: return d ? 3'h0 : 3'h4;
         6: return 3'h0;
         7: return d ? 3'h6 : 3'h5;
         default: return 3'h4;
      endcase
   endfunction
   task automatic wrap_up();
      if (num_errors == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////
   initial
   begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      chk("timeout", 1, 0);
      wrap_up();
   end
   initial
   begin
      {psel, pen, pwrite, paddr, pwdata} = '0;
      {oe_bus, sys_out, bypass, ext_val} = '0;
      rst = 1'h1;
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      #1;
      chk("reset pads", {oe_n, pu, pd, ibuf, irq}, 33'h1FE000000);
      for (int a = 0; a <= 'h38; a += 4)
         if (a != 4)
            rdc(12'(a), 0);
      bus(1'h0, 12'h100, 0);
      chk("unmapped", {err, rd}, 33'h100000000);
      for (int m = 0; m < 8; m++)
         for (int d = 0; d < 2; d++)
         begin
            bus(1'h1, PPC_OFS_DM0, rep(m[0]));
            bus(1'h1, PPC_OFS_DM1, rep(m[1]));
            bus(1'h1, PPC_OFS_DM2, rep(m[2]));
            bus(1'h1, PPC_OFS_OUT, rep(d[0]));
            gap(2);
            e = exp_pad(m, d[0]);
            chk("oe_n", oe_n, rep(e[2]));
            chk("pulls", {pu, pd}, {{8{e[1]}}, {8{e[0]}}});
            if (!e[2])
               chk("data", pin_d, rep(d[0]));
            chk("ibuf", ibuf, rep(m != 0));
         end
      bus(1'h1, PPC_OFS_PIN0 + 12'h00C, 32'h39);
      rdc(PPC_OFS_DM0, 32'hF7);
      rdc(PPC_OFS_SLW, 32'h08);
      gap(2);
      chk("slow", slow, 8'h08);
      bus(1'h1, PPC_OFS_DM2, 32'h77);
      gap(4);
      rdc(PPC_OFS_PIN0 + 12'h00C, 32'h29);
      chk("slow", slow, 8'h00);
      bus(1'h1, PPC_OFS_REG, 32'hA5);
      bus(1'h1, PPC_OFS_DM2, 0);
      bus(1'h1, PPC_OFS_OUT, 0);
      bus(1'h1, PPC_OFS_CTL, 1);
      bus(1'h1, PPC_OFS_SIO, 32'hE4);
      gap(2);
      chk("regulated", {oe_n, pd}, 16'hF752);
      chk("levels", {reg_lvl, thr}, 16'hA5E4);
      chk("lvttl", lvttl, 1);
      bus(1'h1, PPC_OFS_REG, 0);
      bus(1'h1, PPC_OFS_DM0, 32'hFF);
      bus(1'h1, PPC_OFS_DM1, 0);
      bus(1'h1, PPC_OFS_IBD, 32'h0F);
      ext_val <= 8'hFF;
      gap(6);
      chk("ibuf off", {ibuf, pin_in}, 16'hF0F0);
      bus(1'h1, PPC_OFS_IBD, 0);
      bus(1'h1, PPC_OFS_ITL, 32'h05);
      bus(1'h1, PPC_OFS_ITH, 32'h06);
      bus(1'h1, PPC_OFS_OUT, 0);
      ext_val <= 8'h00;
      gap(8);
      rdc(PPC_OFS_STAT, 32'h06);
      @(posedge clk);
      ext_val <= 8'hFF;
      gap(12);
      chk("irq", irq, 1);
      rdc(PPC_OFS_STAT, 32'h05);
      gap(3);
      chk("irq", irq, 0);
      rdc(PPC_OFS_STAT, 0);
      @(posedge clk);
      ext_val <= 8'h00;
      gap(8);
      rdc(PPC_OFS_STAT, 32'h06);
      bus(1'h1, PPC_OFS_DM1, 32'hFF);
      bus(1'h1, PPC_OFS_DM2, 32'hFF);
      bus(1'h1, PPC_OFS_DM0, 0);
      bus(1'h1, PPC_OFS_BIE, 32'h60);
      bus(1'h1, PPC_OFS_OESEL, 32'h0CC0_0000);
      gap(2);
      chk("bidir in", {oe_n, ibuf & 8'h60}, 16'h6060);
      @(posedge clk);
      oe_bus <= 16'h1000;
      bypass <= 8'hFF;
      sys_out <= 8'h0F;
      gap(3);
      chk("bidir out", {oe_n, pin_d}, 16'h000F);
      wrap_up();
   end
endmodule

// *** rtl/ppc_edge_unit.sv ***
// Per-pin edge detector of the port event unit.
// Assumes pin_sync is already synchronised to the clock.
`timescale 1ns/1ps
module ppc_edge_unit
   import ppc_pkg::*;
(
   input wire logic I_CLOCK,
   input wire logic I_RESET,
   ppc_evt_if.det evt
);
   logic [PPC_PINS-1:0] prev_r;
   logic [PPC_PINS-1:0] hit_nxt;

   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
         prev_r <= '0;
      else
         prev_r <= evt.pin_sync;
   end

   // Edges only; a held level never repeats an event.
   always_comb
   begin
      for (int i = 0; i < PPC_PINS; i++)
      begin
         unique case (ppc_it_t'(evt.edge_type[i*PPC_IT_W +: PPC_IT_W]))
            PPC_IT_OFF: hit_nxt[i] = 1'b0;
            PPC_IT_RISE: hit_nxt[i] = evt.pin_sync[i] & ~prev_r[i];
            PPC_IT_FALL: hit_nxt[i] = ~evt.pin_sync[i] & prev_r[i];
            PPC_IT_BOTH: hit_nxt[i] = evt.pin_sync[i] ^ prev_r[i];
         endcase
      end
   end

   assign evt.event_hit = hit_nxt;
endmodule

// *** rtl/ppc_evt_if.sv ***
// Carries pin samples, edge types and events to and from the edge unit.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface ppc_evt_if;
   import ppc_pkg::*;
   logic [PPC_PINS-1:0] pin_sync;
   logic [PPC_PINS*PPC_IT_W-1:0] edge_type;
   logic [PPC_PINS-1:0] event_hit;
   modport ctl (output pin_sync, output edge_type, input event_hit);
   modport det (input pin_sync, input edge_type, output event_hit);
endinterface

// *** rtl/ppc_pkg.sv ***
// Constants shared by the port pin controller and its edge detector.
// Assumes an APB master with 32-bit data and word-aligned addresses.
package ppc_pkg;
   localparam int PPC_PINS = 8;
   localparam int PPC_OE_LINES = 16;
   localparam int PPC_SEL_W = 4;
   localparam int PPC_ADDR_W = 12;
   localparam int PPC_DM_W = 3;
   localparam int PPC_IT_W = 2;
   localparam int PPC_TH_W = 2;

   // Port-form register byte addresses.
   localparam logic [11:0] PPC_OFS_OUT = 12'h000;
   localparam logic [11:0] PPC_OFS_IN = 12'h004;
   localparam logic [11:0] PPC_OFS_DM0 = 12'h008;
   localparam logic [11:0] PPC_OFS_DM1 = 12'h00C;
   localparam logic [11:0] PPC_OFS_DM2 = 12'h010;
   localparam logic [11:0] PPC_OFS_SLW = 12'h014;
   localparam logic [11:0] PPC_OFS_IBD = 12'h018;
   localparam logic [11:0] PPC_OFS_BIE = 12'h01C;
   localparam logic [11:0] PPC_OFS_ITL = 12'h020;
   localparam logic [11:0] PPC_OFS_ITH = 12'h024;
   localparam logic [11:0] PPC_OFS_STAT = 12'h028;
   localparam logic [11:0] PPC_OFS_CTL = 12'h02C;
   localparam logic [11:0] PPC_OFS_REG = 12'h030;
   localparam logic [11:0] PPC_OFS_SIO = 12'h034;
   localparam logic [11:0] PPC_OFS_OESEL = 12'h038;
   // Pin-form registers: one word per pin from this base.
   localparam logic [11:0] PPC_OFS_PIN0 = 12'h040;
   localparam logic [11:0] PPC_OFS_PINEND = 12'h060;

   // Pin-form field positions.
   localparam int PPC_PF_OUT = 0;
   localparam int PPC_PF_IN = 1;
   localparam int PPC_PF_DM = 2;
   localparam int PPC_PF_SLW = 5;
   localparam int PPC_PF_IBD = 6;
   localparam int PPC_PF_BIE = 7;

   localparam logic [31:0] PPC_ZERO = 32'h0000_0000;

   typedef enum logic [2:0]
   {
      PPC_DM_ANALOG = 3'b000,
      PPC_DM_DIGZ = 3'b001,
      PPC_DM_RPU = 3'b010,
      PPC_DM_RPD = 3'b011,
      PPC_DM_ODL = 3'b100,
      PPC_DM_ODH = 3'b101,
      PPC_DM_STRONG = 3'b110,
      PPC_DM_RBOTH = 3'b111
   } ppc_dm_t;

   typedef enum logic [1:0]
   {
      PPC_IT_OFF = 2'b00,
      PPC_IT_RISE = 2'b01,
      PPC_IT_FALL = 2'b10,
      PPC_IT_BOTH = 2'b11
   } ppc_it_t;
endpackage

// *** rtl/ppc_port.sv ***
// What this block does
// - Resistive pull modes: resistor one way, strong other.
// - Open-drain: low mode drives 0, high drives 1.
// - Strong mode drives both levels.
// - Resistive-both pulls up or down by data.
// - Regulated special pin blocks resistive modes.
// - Port-form registers, one bit per pin.
// - Pin-form register shares the same state.
// - Routed output enable switches input and output.
// - Sixteen enable lines, each to any pins.
// - Edge rate per pin, strong and open-drain only.
// - Eight pins feed one event unit request.
// - Edge type per pin: rise, fall, both, off.
// - Selected edge sets status bit and request.
// - Edge detection runs in every low-power mode.
// - Edges only; no level interrupts.
// - Port threshold select CMOS or LVTTL.
// - Input buffer disable per pin.
// - Reset: analog high impedance everywhere.
// - Pin state held through low-power modes.
// - Special pin high level: supply or regulated.
// - Pin pairs share a four-choice threshold.
// - Three-bit drive mode encoding.
// - Digital high-Z: driver off, input on.
//
// APB slave for one eight-pin port with pin drive and edge events.
// Assumes pins arrive asynchronously and the pad decodes the drive outputs.
`timescale 1ns/1ps
module ppc_port
   import ppc_pkg::*;
#(
   parameter int PINS = PPC_PINS,
   parameter int OE_LINES = PPC_OE_LINES
)
(
   input wire logic I_CLOCK,
   input wire logic I_RESET,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [PPC_ADDR_W-1:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic [PINS-1:0] I_PIN,
   input wire logic [OE_LINES-1:0] I_OE_BUS,
   input wire logic [PINS-1:0] I_SYS_OUT,
   input wire logic [PINS-1:0] I_BYPASS,
   output logic [PINS-1:0] O_PIN,
   output logic [PINS-1:0] O_PIN_OE_N,
   output logic [PINS-1:0] O_PULL_UP,
   output logic [PINS-1:0] O_PULL_DOWN,
   output logic [PINS-1:0] O_IN_BUF_EN,
   output logic [PINS-1:0] O_SLOW_EDGE,
   output logic [PINS-1:0] O_PIN_IN,
   output logic O_LVTTL,
   output logic [PINS-1:0] O_REG_LEVEL,
   output logic [PINS*PPC_TH_W/2-1:0] O_PAIR_THRESH,
   output logic O_PORT_IRQ
);
   ////////////////////////////////////////////////////////////////////////
   // Configuration state. Every field lives once; both register forms
   // address the same flops so either write view sees the other.

   logic [PINS-1:0] out_latch_r;
   logic [PINS-1:0] dm0_r;
   logic [PINS-1:0] dm1_r;
   logic [PINS-1:0] dm2_r;
   logic [PINS-1:0] slw_r;
   logic [PINS-1:0] ibd_r;
   logic [PINS-1:0] bie_r;
   logic [PINS-1:0] itl_r;
   logic [PINS-1:0] ith_r;
   logic [PINS-1:0] stat_r;
   logic lvttl_r;
   logic [PINS-1:0] reg_r;
   logic [PINS*PPC_TH_W/2-1:0] sio_th_r;
   logic [PINS*4-1:0] oe_sel_r;
   logic [PINS-1:0] sync1_r;
   logic [PINS-1:0] sync2_r;

   logic wr;
   logic rd;
   logic [PPC_ADDR_W-1:0] pin_ofs;
   logic pin_hit;
   logic [2:0] pin_idx;
   logic [PINS-1:0] pin_mask;
   logic [PINS-1:0] stat_keep;
   logic addr_ok;

   ppc_evt_if evt ();

   assign wr = I_PSEL & I_PENABLE & I_PWRITE;
   assign rd = I_PSEL & I_PENABLE & ~I_PWRITE;
   assign pin_hit = (I_PADDR >= PPC_OFS_PIN0) && (I_PADDR < PPC_OFS_PINEND);
   assign pin_ofs = I_PADDR - PPC_OFS_PIN0;
   assign pin_idx = pin_ofs[4:2];
   assign pin_mask = pin_hit ? PINS'(1) << pin_idx : '0;

   // Writes a full port-form word, or one pin bit from a pin-form word.
   function automatic logic [PINS-1:0] upd(input logic [PINS-1:0] cur,
      input logic port_sel, input int fld);
      logic [PINS-1:0] v;
      v = cur;
      if (port_sel)
         v = I_PWDATA[PINS-1:0];
      else if (|pin_mask)
         v = (cur & ~pin_mask) | ({PINS{I_PWDATA[fld]}} & pin_mask);
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Register writes; reset leaves all pins analog high impedance.

   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
      begin
         out_latch_r <= '0;
         dm0_r <= '0;
         dm1_r <= '0;
         dm2_r <= '0;
         slw_r <= '0;
         ibd_r <= '0;
         bie_r <= '0;
      end
      else if (wr)
      begin
         out_latch_r <= upd(out_latch_r, I_PADDR == PPC_OFS_OUT, PPC_PF_OUT);
         dm0_r <= upd(dm0_r, I_PADDR == PPC_OFS_DM0, PPC_PF_DM);
         dm1_r <= upd(dm1_r, I_PADDR == PPC_OFS_DM1, PPC_PF_DM + 1);
         dm2_r <= upd(dm2_r, I_PADDR == PPC_OFS_DM2, PPC_PF_DM + 2);
         slw_r <= upd(slw_r, I_PADDR == PPC_OFS_SLW, PPC_PF_SLW);
         ibd_r <= upd(ibd_r, I_PADDR == PPC_OFS_IBD, PPC_PF_IBD);
         bie_r <= upd(bie_r, I_PADDR == PPC_OFS_BIE, PPC_PF_BIE);
      end
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
      begin
         itl_r <= '0;
         ith_r <= '0;
         lvttl_r <= 1'b0;
         reg_r <= '0;
         sio_th_r <= '0;
         oe_sel_r <= '0;
      end
      else if (wr)
      begin
         if (I_PADDR == PPC_OFS_ITL)
            itl_r <= I_PWDATA[PINS-1:0];
         if (I_PADDR == PPC_OFS_ITH)
            ith_r <= I_PWDATA[PINS-1:0];
         if (I_PADDR == PPC_OFS_CTL)
            lvttl_r <= I_PWDATA[0];
         if (I_PADDR == PPC_OFS_REG)
            reg_r <= I_PWDATA[PINS-1:0];
         if (I_PADDR == PPC_OFS_SIO)
            sio_th_r <= I_PWDATA[PINS*PPC_TH_W/2-1:0];
         if (I_PADDR == PPC_OFS_OESEL)
            oe_sel_r <= I_PWDATA[PINS*4-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin input synchroniser and the edge unit. The detector needs no
   // wake-up path: it runs on the always-on clock in every power mode.

   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
      begin
         sync1_r <= '0;
         sync2_r <= '0;
      end
      else
      begin
         sync1_r <= I_PIN;
         sync2_r <= sync1_r;
      end
   end

   always_comb
   begin
      for (int i = 0; i < PINS; i++)
      begin
         evt.edge_type[i*PPC_IT_W] = itl_r[i];
         evt.edge_type[i*PPC_IT_W + 1] = ith_r[i];
      end
   end
   // A disabled input buffer blocks events from that pin.
   assign evt.pin_sync = sync2_r & ~ibd_r;

   ppc_edge_unit u_edge
   (
      .I_CLOCK(I_CLOCK),
      .I_RESET(I_RESET),
      .evt(evt.det)
   );

   assign stat_keep = (rd && I_PADDR == PPC_OFS_STAT) ?
      stat_r & ~O_PRDATA[PINS-1:0] : stat_r;

   // A read clears only the bits it returned; a set in that cycle wins.
   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
         stat_r <= '0;
      else
         stat_r <= stat_keep | evt.event_hit;
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
         O_PORT_IRQ <= 1'b0;
      else
         O_PORT_IRQ <= |(stat_keep | evt.event_hit);
   end

   ////////////////////////////////////////////////////////////////////////
   // Pad drive decode. Outputs are registered, so pads settle one clock
   // after a configuration or data change, and hold in low-power modes.

   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
      begin
         O_PIN <= '0;
         O_PIN_OE_N <= '1;
         O_PULL_UP <= '0;
         O_PULL_DOWN <= '0;
         O_IN_BUF_EN <= '0;
         O_SLOW_EDGE <= '0;
      end
      else
      begin
         for (int i = 0; i < PINS; i++)
         begin
            logic d;
            logic oe;
            ppc_dm_t dm;
            d = I_BYPASS[i] ? I_SYS_OUT[i] : out_latch_r[i];
            dm = ppc_dm_t'({dm2_r[i], dm1_r[i], dm0_r[i]});
            // Pull modes are refused on a regulated special pin.
            if (reg_r[i] && (dm == PPC_DM_RPU || dm == PPC_DM_RPD ||
               dm == PPC_DM_RBOTH))
               dm = PPC_DM_DIGZ;
            oe = bie_r[i] ? I_OE_BUS[oe_sel_r[i*4 +: 4]] : 1'b1;
            if (!oe)
               dm = PPC_DM_DIGZ;
            O_PIN[i] <= d;
            O_PIN_OE_N[i] <= 1'b1;
            O_PULL_UP[i] <= 1'b0;
            O_PULL_DOWN[i] <= 1'b0;
            O_SLOW_EDGE[i] <= 1'b0;
            O_IN_BUF_EN[i] <= (dm != PPC_DM_ANALOG) & ~ibd_r[i];
            unique case (dm)
               PPC_DM_ANALOG: O_IN_BUF_EN[i] <= 1'b0;
               PPC_DM_DIGZ: O_PIN_OE_N[i] <= 1'b1;
               PPC_DM_RPU:
               begin
                  O_PIN_OE_N[i] <= d;
                  O_PULL_UP[i] <= d;
               end
               PPC_DM_RPD:
               begin
                  O_PIN_OE_N[i] <= ~d;
                  O_PULL_DOWN[i] <= ~d;
               end
               PPC_DM_ODL:
               begin
                  O_PIN_OE_N[i] <= d;
                  O_SLOW_EDGE[i] <= slw_r[i];
               end
               PPC_DM_ODH:
               begin
                  O_PIN_OE_N[i] <= ~d;
                  O_SLOW_EDGE[i] <= slw_r[i];
               end
               PPC_DM_STRONG:
               begin
                  O_PIN_OE_N[i] <= 1'b0;
                  O_SLOW_EDGE[i] <= slw_r[i];
               end
               PPC_DM_RBOTH:
               begin
                  O_PULL_UP[i] <= d;
                  O_PULL_DOWN[i] <= ~d;
               end
            endcase
         end
      end
   end

   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
      begin
         O_LVTTL <= 1'b0;
         O_REG_LEVEL <= '0;
         O_PAIR_THRESH <= '0;
         O_PIN_IN <= '0;
      end
      else
      begin
         O_LVTTL <= lvttl_r;
         O_REG_LEVEL <= reg_r;
         O_PAIR_THRESH <= sio_th_r;
         O_PIN_IN <= sync2_r & ~ibd_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // APB read path; zero-wait, unmapped addresses answer with an error.

   function automatic logic [31:0] ext(input logic [PINS-1:0] v);
      return {{(32-PINS){1'b0}}, v};
   endfunction

   assign addr_ok = pin_hit || (I_PADDR <= PPC_OFS_OESEL &&
      I_PADDR[1:0] == 2'b00);

   always_ff @(posedge I_CLOCK)
   begin
      if (I_RESET)
      begin
         O_PRDATA <= PPC_ZERO;
         O_PREADY <= 1'b0;
         O_PSLVERR <= 1'b0;
      end
      else
      begin
         O_PREADY <= I_PSEL & ~I_PENABLE;
         O_PSLVERR <= I_PSEL & ~I_PENABLE & ~addr_ok;
         O_PRDATA <= PPC_ZERO;
         if (I_PSEL && !I_PENABLE && !I_PWRITE)
         begin
            if (pin_hit)
               O_PRDATA <= ext({bie_r[pin_idx], ibd_r[pin_idx],
                  slw_r[pin_idx], dm2_r[pin_idx], dm1_r[pin_idx],
                  dm0_r[pin_idx], sync2_r[pin_idx], out_latch_r[pin_idx]});
            else
               unique case (I_PADDR)
                  PPC_OFS_OUT: O_PRDATA <= ext(out_latch_r);
                  PPC_OFS_IN: O_PRDATA <= ext(sync2_r);
                  PPC_OFS_DM0: O_PRDATA <= ext(dm0_r);
                  PPC_OFS_DM1: O_PRDATA <= ext(dm1_r);
                  PPC_OFS_DM2: O_PRDATA <= ext(dm2_r);
                  PPC_OFS_SLW: O_PRDATA <= ext(slw_r);
                  PPC_OFS_IBD: O_PRDATA <= ext(ibd_r);
                  PPC_OFS_BIE: O_PRDATA <= ext(bie_r);
                  PPC_OFS_ITL: O_PRDATA <= ext(itl_r);
                  PPC_OFS_ITH: O_PRDATA <= ext(ith_r);
                  PPC_OFS_STAT: O_PRDATA <= ext(stat_r);
                  PPC_OFS_CTL: O_PRDATA <= {31'h0000_0000, lvttl_r};
                  PPC_OFS_REG: O_PRDATA <= ext(reg_r);
                  PPC_OFS_SIO: O_PRDATA <= {24'h00_0000, sio_th_r};
                  PPC_OFS_OESEL: O_PRDATA <= oe_sel_r;
                  default: O_PRDATA <= PPC_ZERO;
               endcase
         end
      end
   end
endmodule
